// ==== src/spl_pkg.sv ====
// Package for the status panel indicator logic: constants and carrier types
package spl_pkg;

  // ******************************************************************
  // Timing
  // ******************************************************************
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned HALF_SEC_MS  = 500;
  localparam int unsigned HALF_SEC_CYC = (CLK_HZ / 1000) * HALF_SEC_MS;
  localparam logic [6:0]  PAT_STEPS    = 7'h54; // 84 half-seconds: multiple of 3, 4, 6, 7

  // ******************************************************************
  // Train log depths and limits
  // ******************************************************************
  localparam int          LOG_SHORT     = 20;
  localparam int          LOG_LONG      = 40;
  localparam logic [5:0]  LOG_SHORT_N   = 6'h14;
  localparam logic [5:0]  LOG_LONG_N    = 6'h28;
  localparam logic [7:0]  BRG_COLD_F    = 8'h05;
  localparam logic [7:0]  WHL_COLD_F    = 8'h0f;
  localparam logic [7:0]  BRG_DELTA_F   = 8'h14;
  localparam logic [7:0]  WHL_DELTA_F   = 8'h78;
  localparam logic [7:0]  BRG_BAL_F     = 8'h05;
  localparam logic [7:0]  WHL_BAL_F     = 8'h0f;
  localparam logic [2:0]  DELTA_RUN     = 3'h5;
  localparam logic [4:0]  BAL_RUN       = 5'h14;
  localparam logic [7:0]  TD_FAULT_DIFF = 8'h04;
  localparam logic [7:0]  TD_GOOD_DIFF  = 8'h03;
  localparam logic [7:0]  TD_MIN_MPH    = 8'h0a;
  localparam logic [7:0]  NOISE_LIMIT   = 8'h14;

  // ******************************************************************
  // Register map and fields
  // ******************************************************************
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STAT     = 8'h04;
  localparam logic [7:0]  ADDR_CNT      = 8'h08;
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          CTRL_CLR_BIT  = 1;
  localparam logic        CTRL_EN_RST   = 1'b1;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ******************************************************************
  // Synchronised pin bit positions
  // ******************************************************************
  localparam int PIN_PRESENT = 0;
  localparam int PIN_WHEEL1  = 1;
  localparam int PIN_WHEEL2  = 2;
  localparam int PIN_PTT     = 3;
  localparam int PIN_CARRIER = 4;
  localparam int PIN_WAIT    = 5;
  localparam int PIN_GATEACT = 6;
  localparam int PIN_CPU0    = 7;
  localparam int PIN_CPU1    = 8;
  localparam int PIN_BATT    = 9;
  localparam int PIN_N       = 10;

  // Per-train summary; index 0 is the north/east rail, 1 the south/west rail
  typedef struct packed {
    logic [1:0][7:0] brg_max;
    logic [1:0][7:0] whl_max;
    logic [1:0][7:0] brg_avg;
    logic [1:0][7:0] whl_avg;
    logic            res_fail;
    logic [7:0]      cnt1;
    logic [7:0]      cnt2;
    logic [7:0]      axle_cnt;
    logic [7:0]      min_mph;
    logic [7:0]      noise1;
    logic [7:0]      noise2;
    logic [4:0]      alarms;
  } spl_train_s;

  // Entry of the 20-train log
  typedef struct packed {
    logic [3:0] scan_fail; // brg0, brg1, whl0, whl1
    logic       t1_fault;
    logic       t2_fault;
    logic       noise;
    logic       good;
  } spl_entry_s;

endpackage

// ==== src/spl_panel.sv ====
// Status panel indicator logic with AXI4-Lite control and status registers
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
// ********************************************************************
// Summary of operation
// - Scanner red lit while any train in 20-train log failed integrity.
// - Bearing below 5F or wheel below 15F whole train is a failure.
// - Failed shutter resistor check also counts as integrity failure.
// - Five consecutive trains with pair delta over 20F/120F is failure.
// - Red solid if both of a pair failed, flash if one, off if none.
// - North/east failure flashes on 0.5s off 1s; south/west distinct.
// - Scanner yellow flashes while 20 consecutive trains are imbalanced.
// - Lower scanner is faulty; yellow pattern names its rail.
// - Scanner green flashes only when all scanners good; never solid.
// - With train present, wheel pulses show on transducer green/yellow.
// - Transducer red dark during passage unless both transducers failed.
// - Transducer fault needs count diff four+, speed over 10, odd axles.
// - Transducer red solid for faults on both, flash for one.
// - First transducer flash on 0.5 off 1; second on 1 off 2.
// - Transducer yellow lit for noise over 20 pulses or activation.
// - Transducer green flashes when counts differ by three or less.
// - Activity LEDs follow radio transmission and train presence.
// - Hold-off lit on reception, blinks while awaiting announcement.
// - Alarm LEDs lit while category alarm exists in 40-train log.
// - CPU LEDs cycle off, dim, bright, dim while processor healthy.
// - Middle processor LED lit while backup battery is low.
// - Both train logs clear at power-up and reset.
// ********************************************************************
module spl_panel #(
  parameter int unsigned TICK_CYC = spl_pkg::HALF_SEC_CYC
) (
  input  wire logic               I_MCLK,
  input  wire logic               I_SYS_RST,
  input  wire logic               I_TRAIN_DONE,
  input  wire spl_pkg::spl_train_s I_TRAIN_SUM,
  input  wire logic               I_TRAIN_PRESENT,
  input  wire logic               I_WHEEL1,
  input  wire logic               I_WHEEL2,
  input  wire logic               I_RADIO_PTT,
  input  wire logic               I_RADIO_CARRIER,
  input  wire logic               I_ANNOUNCE_WAIT,
  input  wire logic               I_GATE_ACTIVATE,
  input  wire logic [1:0]         I_CPU_OK,
  input  wire logic               I_BATT_LOW,
  input  wire logic [7:0]         I_AXI_AWADDR,
  input  wire logic               I_AXI_AWVALID,
  output logic                    O_AXI_AWREADY,
  input  wire logic [31:0]        I_AXI_WDATA,
  input  wire logic [3:0]         I_AXI_WSTRB,
  input  wire logic               I_AXI_WVALID,
  output logic                    O_AXI_WREADY,
  output logic [1:0]              O_AXI_BRESP,
  output logic                    O_AXI_BVALID,
  input  wire logic               I_AXI_BREADY,
  input  wire logic [7:0]         I_AXI_ARADDR,
  input  wire logic               I_AXI_ARVALID,
  output logic                    O_AXI_ARREADY,
  output logic [31:0]             O_AXI_RDATA,
  output logic [1:0]              O_AXI_RRESP,
  output logic                    O_AXI_RVALID,
  input  wire logic               I_AXI_RREADY,
  output logic [2:0]              O_ROW1,
  output logic [4:0]              O_ROW2,
  output logic [2:0]              O_ROW3,
  output logic [2:0]              O_ROW4,
  output logic [2:0]              O_ROW5
);

  function automatic logic [7:0] adiff(input logic [7:0] a, input logic [7:0] b);
    adiff = (a > b) ? (a - b) : (b - a);
  endfunction

  // ******************************************************************
  // Pin synchronisers
  // ******************************************************************
  logic [spl_pkg::PIN_N-1:0] pin_raw;
  logic [spl_pkg::PIN_N-1:0] meta_reg;
  logic [spl_pkg::PIN_N-1:0] pin_reg;
  assign pin_raw = {I_BATT_LOW, I_CPU_OK, I_GATE_ACTIVATE, I_ANNOUNCE_WAIT, I_RADIO_CARRIER,
                    I_RADIO_PTT, I_WHEEL2, I_WHEEL1, I_TRAIN_PRESENT};
  genvar gi;
  generate
    for (gi = 0; gi < spl_pkg::PIN_N; gi++) begin : g_sync
      always_ff @(posedge I_MCLK) begin
        meta_reg[gi] <= I_SYS_RST ? 1'b0 : pin_raw[gi];
        pin_reg[gi]  <= I_SYS_RST ? 1'b0 : meta_reg[gi];
      end
    end
  endgenerate
  wire present = pin_reg[spl_pkg::PIN_PRESENT];

  // ******************************************************************
  // Half-second timebase and pattern steps
  // ******************************************************************
  logic [23:0] tick_cnt_reg;
  logic        tick_reg;
  logic [6:0]  step_reg;
  logic [3:0]  pwm_reg;
  wire tick_end = (tick_cnt_reg == 24'(TICK_CYC - 1));
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      tick_cnt_reg <= 24'h0;
      tick_reg     <= 1'b0;
      step_reg     <= 7'h0;
      pwm_reg      <= 4'h0;
    end else begin
      tick_cnt_reg <= tick_end ? 24'h0 : tick_cnt_reg + 24'h1;
      tick_reg     <= tick_end;
      pwm_reg      <= pwm_reg + 4'h1;
      if (tick_reg) begin
        step_reg <= (step_reg == spl_pkg::PAT_STEPS - 7'h1) ? 7'h0 : step_reg + 7'h1;
      end
    end
  end
  wire pat_ne   = ((step_reg % 7'h3) == 7'h0);        // On 0.5 s, off 1 s
  wire pat_sw4  = ((step_reg % 7'h4) == 7'h0);        // On 0.5 s, off 1.5 s
  wire pat_sw7  = ((step_reg % 7'h7) == 7'h0);        // On 0.5 s, off 3 s
  wire pat_td2  = ((step_reg % 7'h6) < 7'h2);         // On 1 s, off 2 s
  wire blink    = ~step_reg[0];
  wire [1:0] cpu_phase = step_reg[1:0];
  wire dim      = (pwm_reg[3:2] == 2'h0);             // Quarter duty for the dim level
  wire cpu_lvl  = (cpu_phase == 2'h2) | (cpu_phase[0] & dim);

  // ******************************************************************
  // Per-train evaluation
  // ******************************************************************
  spl_pkg::spl_train_s t;
  assign t = I_TRAIN_SUM;
  logic       ctrl_en_reg;
  logic       clr_reg;
  logic [2:0] delta_run_reg;
  logic [4:0] imb_run_reg;
  logic       imb_rail_reg;
  wire [7:0] brg_d = adiff(t.brg_avg[0], t.brg_avg[1]);
  wire [7:0] whl_d = adiff(t.whl_avg[0], t.whl_avg[1]);
  wire brg_lo1 = t.brg_avg[1] < t.brg_avg[0];
  wire whl_lo1 = t.whl_avg[1] < t.whl_avg[0];
  wire brg_dhit = brg_d > spl_pkg::BRG_DELTA_F;
  wire whl_dhit = whl_d > spl_pkg::WHL_DELTA_F;
  wire [2:0] delta_run_next = (brg_dhit | whl_dhit) ?
               ((delta_run_reg == spl_pkg::DELTA_RUN) ? delta_run_reg : delta_run_reg + 3'h1) :
               3'h0;
  wire delta_fail = (delta_run_next == spl_pkg::DELTA_RUN);
  wire brg_imb = brg_d > spl_pkg::BRG_BAL_F;
  wire whl_imb = whl_d > spl_pkg::WHL_BAL_F;
  wire [4:0] imb_run_next = (brg_imb | whl_imb) ?
               ((imb_run_reg == spl_pkg::BAL_RUN) ? imb_run_reg : imb_run_reg + 5'h1) : 5'h0;
  wire imb_rail_next = brg_imb ? brg_lo1 : whl_lo1;
  wire [7:0] td_d = adiff(t.cnt1, t.cnt2);
  wire td_fault = (td_d >= spl_pkg::TD_FAULT_DIFF) && (t.min_mph > spl_pkg::TD_MIN_MPH)
                  && t.axle_cnt[0];
  wire t1_fewer = t.cnt1 < t.cnt2;

  spl_pkg::spl_entry_s entry_new;
  assign entry_new.scan_fail[0] = (t.brg_max[0] < spl_pkg::BRG_COLD_F) | t.res_fail
                                  | (delta_fail & brg_dhit & ~brg_lo1);
  assign entry_new.scan_fail[1] = (t.brg_max[1] < spl_pkg::BRG_COLD_F) | t.res_fail
                                  | (delta_fail & brg_dhit & brg_lo1);
  assign entry_new.scan_fail[2] = (t.whl_max[0] < spl_pkg::WHL_COLD_F)
                                  | (delta_fail & whl_dhit & ~whl_lo1);
  assign entry_new.scan_fail[3] = (t.whl_max[1] < spl_pkg::WHL_COLD_F)
                                  | (delta_fail & whl_dhit & whl_lo1);
  assign entry_new.t1_fault = td_fault & t1_fewer;
  assign entry_new.t2_fault = td_fault & ~t1_fewer;
  assign entry_new.noise = (t.noise1 > spl_pkg::NOISE_LIMIT) | (t.noise2 > spl_pkg::NOISE_LIMIT);
  assign entry_new.good = (td_d <= spl_pkg::TD_GOOD_DIFF);

  // ******************************************************************
  // Train logs
  // ******************************************************************
  spl_pkg::spl_entry_s short_log [0:spl_pkg::LOG_SHORT-1];
  logic [4:0]          long_log  [0:spl_pkg::LOG_LONG-1];
  logic [5:0]          short_fill_reg;
  logic [5:0]          long_fill_reg;
  // Clear beats a train logged in the same cycle
  wire log_clear = I_SYS_RST | clr_reg;
  always_ff @(posedge I_MCLK) begin
    if (log_clear) begin
      for (int i = 0; i < spl_pkg::LOG_SHORT; i++) short_log[i] <= '0;
      for (int i = 0; i < spl_pkg::LOG_LONG; i++) long_log[i] <= 5'h0;
      short_fill_reg <= 6'h0;
      long_fill_reg  <= 6'h0;
      delta_run_reg  <= 3'h0;
      imb_run_reg    <= 5'h0;
      imb_rail_reg   <= 1'b0;
    end else if (I_TRAIN_DONE) begin
      short_log[0] <= entry_new;
      for (int i = 1; i < spl_pkg::LOG_SHORT; i++) short_log[i] <= short_log[i-1];
      long_log[0] <= t.alarms;
      for (int i = 1; i < spl_pkg::LOG_LONG; i++) long_log[i] <= long_log[i-1];
      if (short_fill_reg != spl_pkg::LOG_SHORT_N) short_fill_reg <= short_fill_reg + 6'h1;
      if (long_fill_reg != spl_pkg::LOG_LONG_N) long_fill_reg <= long_fill_reg + 6'h1;
      delta_run_reg <= delta_run_next;
      imb_run_reg   <= imb_run_next;
      if (brg_imb | whl_imb) imb_rail_reg <= imb_rail_next;
    end
  end

  // Old entries fall off the end, so a failure ages out after 20 or 40 trains
  spl_pkg::spl_entry_s acc_s [0:spl_pkg::LOG_SHORT];
  logic [4:0]          acc_l [0:spl_pkg::LOG_LONG];
  assign acc_s[0] = '0;
  assign acc_l[0] = 5'h0;
  generate
    for (gi = 0; gi < spl_pkg::LOG_SHORT; gi++) begin : g_or_s
      assign acc_s[gi+1] = acc_s[gi] | short_log[gi];
    end
    for (gi = 0; gi < spl_pkg::LOG_LONG; gi++) begin : g_or_l
      assign acc_l[gi+1] = acc_l[gi] | long_log[gi];
    end
  endgenerate
  spl_pkg::spl_entry_s win;
  assign win = acc_s[spl_pkg::LOG_SHORT];

  // ******************************************************************
  // Indicator decode
  // ******************************************************************
  wire [3:0] sf = win.scan_fail;
  wire scan_solid = (sf[0] & sf[1]) | (sf[2] & sf[3]);
  wire scan_ne    = sf[0] | sf[2];
  wire scan_any   = |sf;
  wire r5_red = scan_solid | (scan_ne ? pat_ne : (scan_any & pat_sw4));
  wire r5_yel = (imb_run_reg == spl_pkg::BAL_RUN) & (imb_rail_reg ? pat_sw7 : pat_ne);
  wire r5_grn = ~scan_any & blink;
  wire td_both = win.t1_fault & win.t2_fault;
  wire r4_red_idle = td_both | (win.t1_fault ? pat_ne : (win.t2_fault & pat_td2));
  wire r4_red = present ? td_both : r4_red_idle;
  wire r4_yel = present ? pin_reg[spl_pkg::PIN_WHEEL2]
                        : (win.noise | pin_reg[spl_pkg::PIN_GATEACT]);
  wire r4_grn = present ? pin_reg[spl_pkg::PIN_WHEEL1]
                        : ((short_fill_reg != 6'h0) & short_log[0].good & blink);
  wire r3_hold = pin_reg[spl_pkg::PIN_CARRIER] & (~pin_reg[spl_pkg::PIN_WAIT] | blink);
  wire [2:0] r1 = {pin_reg[spl_pkg::PIN_CPU1] & cpu_lvl, pin_reg[spl_pkg::PIN_BATT],
                   pin_reg[spl_pkg::PIN_CPU0] & cpu_lvl};
  wire [2:0] r3 = {r3_hold, pin_reg[spl_pkg::PIN_PTT], present};
  wire en = ctrl_en_reg;

  // One register stage on every row, so no row glitches while decode settles
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      O_ROW1 <= 3'h0;
      O_ROW2 <= 5'h0;
      O_ROW3 <= 3'h0;
      O_ROW4 <= 3'h0;
      O_ROW5 <= 3'h0;
    end else begin
      O_ROW1 <= en ? r1 : 3'h0;
      O_ROW2 <= en ? acc_l[spl_pkg::LOG_LONG] : 5'h0;
      O_ROW3 <= en ? r3 : 3'h0;
      O_ROW4 <= en ? {r4_red, r4_yel, r4_grn} : 3'h0;
      O_ROW5 <= en ? {r5_red, r5_yel, r5_grn} : 3'h0;
    end
  end

  // ******************************************************************
  // AXI4-Lite slave
  // ******************************************************************
  logic        aw_full_reg;
  logic        w_full_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic        wstrb0_reg;
  wire aw_hs = I_AXI_AWVALID & O_AXI_AWREADY;
  wire w_hs  = I_AXI_WVALID & O_AXI_WREADY;
  wire ar_hs = I_AXI_ARVALID & O_AXI_ARREADY;
  wire do_wr = aw_full_reg & w_full_reg & ~O_AXI_BVALID;
  wire wr_ctrl = do_wr & (awaddr_reg == spl_pkg::ADDR_CTRL);
  wire wr_ok = (awaddr_reg == spl_pkg::ADDR_CTRL) | (awaddr_reg == spl_pkg::ADDR_STAT)
               | (awaddr_reg == spl_pkg::ADDR_CNT);
  wire rd_ctrl = I_AXI_ARADDR == spl_pkg::ADDR_CTRL;
  wire rd_stat = I_AXI_ARADDR == spl_pkg::ADDR_STAT;
  wire rd_cnt  = I_AXI_ARADDR == spl_pkg::ADDR_CNT;
  // Read data is captured at the address handshake, so it stands until RREADY
  wire [31:0] rd_data = rd_ctrl ? {31'h0, ctrl_en_reg} :
                        rd_stat ? {15'h0, O_ROW1, O_ROW2, O_ROW3, O_ROW4, O_ROW5} :
                        rd_cnt  ? {11'h0, imb_rail_reg, imb_run_reg, delta_run_reg,
                                   long_fill_reg, short_fill_reg} : 32'h0;

  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      O_AXI_AWREADY <= 1'b1;
      O_AXI_WREADY  <= 1'b1;
      O_AXI_BVALID  <= 1'b0;
      O_AXI_BRESP   <= spl_pkg::RESP_OKAY;
      aw_full_reg   <= 1'b0;
      w_full_reg    <= 1'b0;
      awaddr_reg    <= 8'h0;
      wdata_reg     <= 32'h0;
      wstrb0_reg    <= 1'b0;
      ctrl_en_reg   <= spl_pkg::CTRL_EN_RST;
      clr_reg       <= 1'b0;
    end else begin
      clr_reg <= 1'b0;
      if (aw_hs) begin
        aw_full_reg   <= 1'b1;
        awaddr_reg    <= I_AXI_AWADDR;
        O_AXI_AWREADY <= 1'b0;
      end
      if (w_hs) begin
        w_full_reg   <= 1'b1;
        wdata_reg    <= I_AXI_WDATA;
        wstrb0_reg   <= I_AXI_WSTRB[0];
        O_AXI_WREADY <= 1'b0;
      end
      if (do_wr) begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        O_AXI_BVALID <= 1'b1;
        O_AXI_BRESP  <= wr_ok ? spl_pkg::RESP_OKAY : spl_pkg::RESP_SLVERR;
        if (wr_ctrl & wstrb0_reg) begin
          ctrl_en_reg <= wdata_reg[spl_pkg::CTRL_EN_BIT];
          clr_reg     <= wdata_reg[spl_pkg::CTRL_CLR_BIT];
        end
      end
      if (O_AXI_BVALID & I_AXI_BREADY) begin
        O_AXI_BVALID  <= 1'b0;
        O_AXI_AWREADY <= 1'b1;
        O_AXI_WREADY  <= 1'b1;
      end
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      O_AXI_ARREADY <= 1'b1;
      O_AXI_RVALID  <= 1'b0;
      O_AXI_RDATA   <= 32'h0;
      O_AXI_RRESP   <= spl_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      O_AXI_ARREADY <= 1'b0;
      O_AXI_RVALID  <= 1'b1;
      O_AXI_RDATA   <= rd_data;
      O_AXI_RRESP   <= (rd_ctrl | rd_stat | rd_cnt) ? spl_pkg::RESP_OKAY : spl_pkg::RESP_SLVERR;
    end else if (O_AXI_RVALID & I_AXI_RREADY) begin
      O_AXI_RVALID  <= 1'b0;
      O_AXI_ARREADY <= 1'b1;
    end
  end

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_SYS_RST);

  AST_LOG_CLEARED: assert property (clr_reg |=> short_fill_reg == 6'h0 && long_fill_reg == 6'h0)
    else $error("Logs not cleared");
  AST_SCAN_SOLID: assert property (en && scan_solid && $stable(en) |=> O_ROW5[2])
    else $error("Scanner red not solid");
  AST_SCAN_GREEN: assert property (scan_any |=> !O_ROW5[0])
    else $error("Scanner green lit with failure logged");
  AST_YEL_IDLE: assert property (imb_run_reg != spl_pkg::BAL_RUN |=> !O_ROW5[1])
    else $error("Scanner yellow without imbalance run");
  AST_WHEEL1: assert property (en && present && pin_reg[spl_pkg::PIN_WHEEL1] && $stable(en)
                               |=> O_ROW4[0])
    else $error("Wheel pulse not shown");
  AST_TD_DARK: assert property (present && !td_both |=> !O_ROW4[2])
    else $error("Transducer red lit during passage");
  AST_PTT: assert property (en && $stable(en) |=> O_ROW3[1] == $past(pin_reg[spl_pkg::PIN_PTT]))
    else $error("PTT indicator mismatch");
  AST_BATT: assert property (en && $stable(en) |=> O_ROW1[1] == $past(pin_reg[spl_pkg::PIN_BATT]))
    else $error("Battery indicator mismatch");
  AST_ALARM: assert property (I_TRAIN_DONE && t.alarms[0] && !clr_reg && en ##1 en[*2]
                              |-> O_ROW2[0])
    else $error("Alarm indicator not lit");
  AST_TICK_SPACING: assert property (tick_reg |=> !tick_reg)
    else $error("Tick not a single pulse");

  COV_SCAN_SOLID: cover property (O_ROW5[2] && scan_solid);
  COV_IMBALANCE:  cover property (imb_run_reg == spl_pkg::BAL_RUN);
  COV_TD_FAULT:   cover property (I_TRAIN_DONE && td_fault);
  COV_AXI_WRITE:  cover property (wr_ctrl);

endmodule // spl_panel

// ==== bench/spl_train_src.sv ====
// Partner model: wayside source of logged per-train summaries
`timescale 1ns/1ps
module spl_train_src (
  input  wire logic           i_clk,
  output logic                o_done,
  output spl_pkg::spl_train_s o_sum
);
  initial begin
    o_done = 1'b0;
    o_sum  = '0;
  end
  // One summary per one-clock pulse; afterwards junk, so stale data is never read
  task automatic send(input spl_pkg::spl_train_s s);
    @(posedge i_clk);
    o_done <= 1'b1;
    o_sum  <= s;
    @(posedge i_clk);
    o_done <= 1'b0;
    o_sum  <= ~s;
  endtask
endmodule // spl_train_src

// ==== bench/tb_top.sv ====
// Testbench for the status panel indicator logic
`timescale 1ns/1ps
module tb_top;
  localparam int TK = 16;
  localparam spl_pkg::spl_train_s GOOD = '{16'h6464, 16'h6464, 16'h5050, 16'h5050, 1'b0,
    8'h10, 8'h10, 8'h10, 8'h28, 8'h00, 8'h00, 5'h00};
  logic              clk, rst, pres, w1, w2, ptt, car, wt, batt, ga, awv, wv, bry, arv, rry;
  logic [1:0]        cpu;
  logic [7:0]        awa, ara;
  logic [31:0]       wd;
  wire logic         done, awr, wr, bv, arr, rv;
  wire logic [1:0]   br, rr;
  wire logic [31:0]  rd;
  wire logic [2:0]   r1, r3, r4, r5;
  wire logic [4:0]   r2;
  wire spl_pkg::spl_train_s sum;
  wire logic [16:0]  pv = {r1, r2, r3, r4, r5};
  int                err_count = 0;
  int                tests_run = 0;
  spl_train_src src (.i_clk(clk), .o_done(done), .o_sum(sum));
  spl_panel #(.TICK_CYC(TK)) dut (.I_MCLK(clk), .I_SYS_RST(rst), .I_TRAIN_DONE(done),
    .I_TRAIN_SUM(sum), .I_TRAIN_PRESENT(pres), .I_WHEEL1(w1), .I_WHEEL2(w2), .I_RADIO_PTT(ptt),
    .I_RADIO_CARRIER(car), .I_ANNOUNCE_WAIT(wt), .I_GATE_ACTIVATE(ga), .I_CPU_OK(cpu),
    .I_BATT_LOW(batt), .I_AXI_AWADDR(awa), .I_AXI_AWVALID(awv), .O_AXI_AWREADY(awr),
    .I_AXI_WDATA(wd), .I_AXI_WSTRB(4'hf), .I_AXI_WVALID(wv), .O_AXI_WREADY(wr),
    .O_AXI_BRESP(br), .O_AXI_BVALID(bv), .I_AXI_BREADY(bry), .I_AXI_ARADDR(ara),
    .I_AXI_ARVALID(arv), .O_AXI_ARREADY(arr), .O_AXI_RDATA(rd), .O_AXI_RRESP(rr),
    .O_AXI_RVALID(rv), .I_AXI_RREADY(rry), .O_ROW1(r1), .O_ROW2(r2), .O_ROW3(r3),
    .O_ROW4(r4), .O_ROW5(r5));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stl(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Window is a whole number of pattern periods, so the count is phase independent
  task automatic onc(input int b, input int nt, input int e, input string n);
    int c = 0;
    repeat (nt * TK) begin
      @(posedge clk);
      c += (pv[b] === 1'b1);
    end
    chk(n, c, e);
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa;
    logic pw;
    @(posedge clk);
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    bry <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    // Each channel lets go at its own handshake; the slave may take them apart
    while (pa | pw) begin
      @(posedge clk);
      if (pa && awr === 1'b1) begin
        awv <= 1'b0;
        pa = 1'b0;
      end
      if (pw && wr === 1'b1) begin
        wv <= 1'b0;
        pw = 1'b0;
      end
    end
    do @(posedge clk); while (bv !== 1'b1);
    r = br;
    bry <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    d = rd;
    r = rr;
    rry <= 1'b0;
  endtask
  task automatic sendw(input spl_pkg::spl_train_s t, input int n);
    repeat (n) src.send(t);
    stl(2);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_bus();
    logic [31:0] d;
    logic [1:0] r;
    stl(2);
    chk("rst", pv, 17'h1);
    axr(spl_pkg::ADDR_CTRL, d, r);
    chk("ctrl", d[0], spl_pkg::CTRL_EN_RST);
    axr(8'h40, d, r);
    chk("rresp", r, spl_pkg::RESP_SLVERR);
    axw(8'h40, 32'h0, r);
    chk("bresp", r, spl_pkg::RESP_SLVERR);
    $display("end t_bus");
  endtask
  task automatic t_rst();
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    stl(2);
    chk("rrst", {r2, r4, r5[2:1]}, 10'h0);
    axr(spl_pkg::ADDR_CNT, d, r);
    chk("rcnt", d, 32'h0);
    $display("end t_rst");
  endtask
  task automatic t_pin();
    @(posedge clk);
    batt <= 1'b1; ptt <= 1'b1; pres <= 1'b1; w1 <= 1'b1; car <= 1'b1; cpu <= 2'h1;
    stl(4);
    chk("row1", r1[1], 1'b1);
    chk("row3", r3, 3'h7);
    chk("row4", r4, 3'h1);
    onc(14, 4, 24, "cpu0");
    onc(16, 4, 0, "cpu1");
    wt <= 1'b1; w1 <= 1'b0; w2 <= 1'b1;
    stl(4);
    chk("row4b", r4, 3'h2);
    onc(8, 4, 2 * TK, "hold");
    {batt, ptt, pres, w2, car, wt} <= '0;
    ga <= 1'b1;
    stl(4);
    chk("off", {r1[1], r3}, 4'h0);
    chk("gate", r4, 3'h2);
    @(posedge clk);
    ga <= 1'b0;
    stl(4);
    chk("gateoff", r4[1], 1'b0);
    $display("end t_pin");
  endtask
  task automatic t_log();
    spl_pkg::spl_train_s t;
    logic [1:0] r;
    logic [31:0] d;
    t = GOOD; t.alarms = 5'h15;
    sendw(t, 1);
    chk("alm", r2, 5'h15);
    sendw(GOOD, 39);
    chk("alm39", r2, 5'h15);
    sendw(GOOD, 1);
    chk("alm40", r2, 5'h00);
    onc(0, 12, 6 * TK, "grn");
    t = GOOD; t.brg_max[0] = 8'h03;
    sendw(t, 1);
    onc(2, 12, 4 * TK, "redne");
    onc(0, 12, 0, "grnoff");
    t.brg_max[1] = 8'h03;
    sendw(t, 1);
    onc(2, 12, 12 * TK, "redsol");
    sendw(GOOD, 19);
    chk("red19", r5[2], 1'b1);
    sendw(GOOD, 1);
    chk("red20", r5[2], 1'b0);
    t = GOOD; t.brg_avg = 16'h4850;
    sendw(t, 19);
    chk("yel19", r5[1], 1'b0);
    sendw(t, 1);
    onc(1, 14, 2 * TK, "yelsw");
    t = GOOD; t.res_fail = 1'b1;
    sendw(t, 1);
    onc(2, 12, 12 * TK, "res");
    axw(spl_pkg::ADDR_CTRL, 32'h0, r);
    stl(2);
    chk("dis", pv, 17'h0);
    axw(spl_pkg::ADDR_CTRL, 32'h3, r);
    chk("wok", r, spl_pkg::RESP_OKAY);
    stl(2);
    chk("clr", {r2, r4, r5[2:1]}, 10'h0);
    axr(spl_pkg::ADDR_CNT, d, r);
    chk("cnt", d, 32'h0);
    t = GOOD; t.cnt2 = 8'h0c; t.axle_cnt = 8'h11; t.min_mph = 8'h0b;
    sendw(t, 1);
    onc(5, 12, 4 * TK, "td2");
    t.cnt1 = 8'h08;
    sendw(t, 1);
    onc(5, 12, 12 * TK, "tdsol");
    t = GOOD; t.cnt2 = 8'h0d; t.axle_cnt = 8'h11; t.min_mph = 8'h05;
    sendw(t, 1);
    onc(3, 12, 6 * TK, "tdgrn");
    t = GOOD; t.noise1 = 8'h15;
    sendw(t, 1);
    chk("noise", r4[1], 1'b1);
    t = GOOD;
    t.whl_avg = 16'h1090;
    sendw(t, 4);
    chk("dlt4", r5[2], 1'b0);
    sendw(t, 1);
    onc(2, 12, 3 * TK, "dltsw");
    $display("end t_log");
  endtask
  initial begin
    rst = 1'b1;
    {pres, w1, w2, ptt, car, wt, batt, ga, awv, wv, bry, arv, rry} = '0;
    cpu = '0; awa = '0; ara = '0; wd = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_bus();
    t_pin();
    t_log();
    t_rst();
    stop_test();
  end
  initial begin
    #2_000_000;
    err_count++;
    stop_test();
  end
endmodule // tb_top
